// File: cpq_params.svh
`ifndef CPQ_PARAMS_SVH
`define CPQ_PARAMS_SVH
// Word and address widths
`define CPQ_WORD_W        16
`define CPQ_ADDR_W        20
`define CPQ_SEG_SHIFT     4
// Queue depths of the two bus variants
`define CPQ_NARROW_DEPTH  4
`define CPQ_WIDE_DEPTH    6
// Free bytes needed before a prefetch starts
`define CPQ_NARROW_NEED   3'h1
`define CPQ_WIDE_NEED     3'h2
// Register select codes
`define CPQ_R_ACC         4'h0
`define CPQ_R_BASE        4'h1
`define CPQ_R_COUNT       4'h2
`define CPQ_R_DEXT        4'h3
`define CPQ_R_SP          4'h4
`define CPQ_R_FP          4'h5
`define CPQ_R_SRC         4'h6
`define CPQ_R_TGT         4'h7
`define CPQ_R_CS          4'h8
`define CPQ_R_DS          4'h9
`define CPQ_R_SS          4'hA
`define CPQ_R_ES          4'hB
// Reset values
`define CPQ_IP_RST        16'h0000
`define CPQ_REG_RST       16'h0000
`endif

// File: cpq_pkg.sv
package cpq_pkg;
   typedef logic [15:0] cpq_word_t;             // Execution datapath word
   typedef logic [19:0] cpq_addr_t;             // Relocated bus address
   typedef enum logic [2:0] {
      REG_NOP, REG_RD, REG_WR_WORD, REG_WR_LOW, REG_WR_HIGH, REG_MUL_BYTE, REG_MUL_WORD
   } cpq_regop_t;                               // Register port operations
   typedef enum logic [1:0] {SEG_DATA, SEG_EXTRA, SEG_STACK} cpq_seg_t;
   typedef enum logic [1:0] {BST_IDLE, BST_FETCH, BST_OPER} cpq_bst_t;
   typedef struct packed {                      // Operand request from execution
      logic      req;
      logic      wr;
      logic      word;
      logic      io;
      cpq_seg_t  seg;
      cpq_word_t ofs;
      cpq_word_t wdata;
   } cpq_opr_t;
   typedef struct packed {                      // External bus request
      logic      req;
      logic      wr;
      logic      word;
      logic      io;
      cpq_addr_t addr;
      cpq_word_t wdata;
   } cpq_bus_t;
   typedef struct packed {                      // Whole core state
      cpq_bst_t              bst;
      logic [7:0][15:0]      gpr;
      logic [3:0][15:0]      seg;
      cpq_word_t             ip;
      logic                  discard;
      logic                  opr_pend;
      cpq_opr_t              opr;
      cpq_bus_t              bus;
      logic                  opr_done;
      cpq_word_t             opr_rdata;
      cpq_word_t             reg_rdata;
      cpq_word_t             saved_ip;
   } cpq_core_st_t;
endpackage : cpq_pkg

// File: cpq_queue.sv
`timescale 1ns/100ps
`default_nettype none
module cpq_queue #(
   parameter int DEPTH = 6
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       flush,      // Drop every byte
   input  wire logic [1:0] push_n,     // Bytes appended this cycle
   input  wire logic [15:0] push_data, // Low byte is the lower address
   input  wire logic       pop,        // Head byte consumed
   output logic [7:0]      head,
   output logic [2:0]      count,
   output logic [2:0]      free
);
   typedef struct packed {
      logic [DEPTH-1:0][7:0] mem;     // Entry 0 is the head
      logic [2:0]            cnt;
   } cpq_queue_st_t;
   cpq_queue_st_t s_reg, s_next;
   logic [2:0] base;                  // Fill level after the pop

   generate
      if (DEPTH < 2 || DEPTH > 7) begin : g_bad
         $error("cpq_queue depth out of range");
      end
   endgenerate

   // Shift out on pop, append in address order
   always_comb begin
      s_next = s_reg;
      base   = s_reg.cnt;
      if (flush) begin
         s_next.cnt = 3'h0;
      end else begin
         if (pop && s_reg.cnt != 3'h0) begin
            s_next.mem = s_reg.mem >> 8;
            base = s_reg.cnt - 3'h1;
         end
         for (int i = 0; i < DEPTH; i++) begin
            if (push_n != 2'h0 && 3'(i) == base) s_next.mem[i] = push_data[7:0];
            if (push_n == 2'h2 && 3'(i) == base + 3'h1) s_next.mem[i] = push_data[15:8];
         end
         s_next.cnt = base + {1'b0, push_n};
      end
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign head  = s_reg.mem[0];
   assign count = s_reg.cnt;
   assign free  = 3'(DEPTH) - s_reg.cnt;
endmodule // cpq_queue
`default_nettype wire

// File: cpq_core.sv
// Summary of operation
// [RL1] Execution registers and paths are 16 bits
// [RL2] Instructions come only from the queue
// [RL3] Operand accesses go through the bus part
// [RL4] 16-bit offsets relocated into megabyte space
// [RL5] Queue holds four or six bytes
// [RL6] Narrow: fetch a byte when one free
// [RL7] Wide: fetch only with two free
// [RL8] Wide: word fetches, odd target byte first
// [RL9] Queue holds following bytes in order
// [RL10] Jump flushes queue, refetches from target
// [RL11] Operand request pauses prefetch after current
// [RL12] Eight 16-bit general registers
// [RL13] Byte access only for data registers
// [RL14] Multiply, divide, port I/O use accumulator
// [RL15] Count and index registers feed strings, shifts
// [RL16] Four segment bases, 64k segments
// [RL17] Code base fetches, stack base stacks
// [RL18] Segment registers readable and writable
// [RL19] Pointer saved as next executed offset
// [RL20] No overfill; execution stalls when empty
`include "cpq_params.svh"
`timescale 1ns/100ps
`default_nettype none
module cpq_core #(
   parameter bit WIDE_BUS = 1'b1              // 1: wide-bus variant
) (
   // Clock, reset, enable
   input  wire logic               REF_CLK,
   input  wire logic               RST,
   input  wire logic               CE,
   // External bus
   output cpq_pkg::cpq_bus_t       BUS,
   input  wire logic               BUS_ACK,
   input  wire cpq_pkg::cpq_word_t BUS_RDATA,
   // Instruction stream to the decoder
   output logic                    INS_VALID,
   output logic [7:0]              INS_BYTE,
   input  wire logic               INS_TAKE,
   input  wire logic               JMP_REQ,
   input  wire cpq_pkg::cpq_word_t JMP_OFS,
   // Operand requests
   input  wire cpq_pkg::cpq_opr_t  OPR,
   output logic                    OPR_DONE,
   output cpq_pkg::cpq_word_t      OPR_RDATA,
   // Register port
   input  wire cpq_pkg::cpq_regop_t REG_OP,
   input  wire logic [3:0]         REG_SEL,
   input  wire cpq_pkg::cpq_word_t REG_WDATA,
   input  wire logic [31:0]        MUL_RES,
   output cpq_pkg::cpq_word_t      REG_RDATA,
   // Implicit register views
   output cpq_pkg::cpq_word_t      ACC_WORD,
   output logic [7:0]              SHIFT_COUNT,
   output cpq_pkg::cpq_word_t      STRING_COUNT,
   output cpq_pkg::cpq_word_t      SRC_INDEX,
   output cpq_pkg::cpq_word_t      TGT_INDEX,
   output cpq_pkg::cpq_word_t      SAVED_IP
);
   localparam int DEPTH = WIDE_BUS ? `CPQ_WIDE_DEPTH : `CPQ_NARROW_DEPTH;
   localparam logic [2:0] NEED = WIDE_BUS ? `CPQ_WIDE_NEED : `CPQ_NARROW_NEED;

   cpq_pkg::cpq_core_st_t s_reg, s_next;     // All core state
   logic [7:0]  q_head;                       // Queue head byte
   logic [2:0]  q_count;                      // Bytes held
   logic [2:0]  q_free;                       // Bytes free
   logic [1:0]  q_push;                       // Bytes appended
   logic        q_pop;                        // Head consumed
   logic        fetch_go;                     // Prefetch may start
   logic        fetch_word;                   // Prefetch is two bytes
   logic        fetch_ack;                    // Prefetch answered

   // Data registers alone take byte access
   function automatic logic is_data_reg(input logic [3:0] sel);
      return sel[3:2] == 2'b00; // RL13
   endfunction

   // Whole-word register read
   function automatic cpq_pkg::cpq_word_t reg_read(input cpq_pkg::cpq_core_st_t st,
                                                   input logic [3:0] sel);
      if (sel[3]) return st.seg[sel[1:0]]; // RL18
      return st.gpr[sel[2:0]];
   endfunction

   // Relocate an offset by a segment base
   function automatic cpq_pkg::cpq_addr_t relocate(input cpq_pkg::cpq_word_t base,
                                                   input cpq_pkg::cpq_word_t ofs);
      return {base, 4'h0} + {4'h0, ofs}; // RL4 RL16
   endfunction

   // Segment used by an operand access
   function automatic cpq_pkg::cpq_word_t opr_base(input cpq_pkg::cpq_core_st_t st,
                                                   input cpq_pkg::cpq_seg_t sg);
      unique case (sg)
         cpq_pkg::SEG_STACK: return st.seg[`CPQ_R_SS - `CPQ_R_CS]; // RL17
         cpq_pkg::SEG_EXTRA: return st.seg[`CPQ_R_ES - `CPQ_R_CS];
         default:            return st.seg[`CPQ_R_DS - `CPQ_R_CS];
      endcase
   endfunction

   // Instruction byte queue
   cpq_queue #(.DEPTH(DEPTH)) u_queue (
      .clk       (REF_CLK),
      .rst       (RST),
      .ce        (CE),
      .flush     (JMP_REQ),
      .push_n    (q_push),
      .push_data (fetch_word ? BUS_RDATA
                  : {8'h00, (WIDE_BUS && s_reg.ip[0]) ? BUS_RDATA[15:8] : BUS_RDATA[7:0]}),
      .pop       (q_pop),
      .head      (q_head),
      .count     (q_count),
      .free      (q_free)
   );

   // Prefetch gating and queue strobes
   always_comb begin
      fetch_word = WIDE_BUS && !s_reg.ip[0]; // RL8
      fetch_go   = q_free >= NEED && !s_reg.opr_pend && !OPR.req; // RL6 RL7 RL11 RL20
      fetch_ack  = s_reg.bst == cpq_pkg::BST_FETCH && BUS_ACK;
      q_push     = (fetch_ack && !s_reg.discard && !JMP_REQ)
                   ? (fetch_word ? 2'h2 : 2'h1) : 2'h0; // RL9
      q_pop      = INS_TAKE && q_count != 3'h0 && !JMP_REQ; // RL2 RL20
   end

   // Next-state logic
   always_comb begin
      s_next          = s_reg;
      s_next.opr_done = 1'b0;
      // Latch an operand request until served
      if (OPR.req && !s_reg.opr_pend) begin
         s_next.opr_pend = 1'b1; // RL3
         s_next.opr      = OPR;
      end
      // Bus sequencer
      unique case (s_reg.bst)
         cpq_pkg::BST_IDLE: begin
            if (s_reg.opr_pend) begin
               s_next.bst        = cpq_pkg::BST_OPER; // RL11
               s_next.bus.req    = 1'b1;
               s_next.bus.wr     = s_reg.opr.wr;
               s_next.bus.word   = s_reg.opr.word;
               s_next.bus.io     = s_reg.opr.io;
               s_next.bus.addr   = s_reg.opr.io ? {4'h0, s_reg.opr.ofs}
                                   : relocate(opr_base(s_reg, s_reg.opr.seg), s_reg.opr.ofs);
               s_next.bus.wdata  = s_reg.opr.io ? s_reg.gpr[`CPQ_R_ACC] // RL14
                                   : s_reg.opr.wdata;
            end else if (fetch_go && !JMP_REQ) begin
               s_next.bst        = cpq_pkg::BST_FETCH;
               s_next.bus.req    = 1'b1;
               s_next.bus.wr     = 1'b0;
               s_next.bus.word   = fetch_word;
               s_next.bus.io     = 1'b0;
               s_next.bus.addr   = relocate(s_reg.seg[0], s_reg.ip); // RL17
               s_next.bus.wdata  = 16'h0000;
            end
         end
         cpq_pkg::BST_FETCH: begin
            if (BUS_ACK) begin
               s_next.bst     = cpq_pkg::BST_IDLE;
               s_next.bus.req = 1'b0;
               s_next.discard = 1'b0;
               if (!s_reg.discard && !JMP_REQ) begin
                  s_next.ip = s_reg.ip + {14'h0, q_push}; // RL19
               end
            end else if (JMP_REQ) begin
               s_next.discard = 1'b1; // RL10
            end
         end
         cpq_pkg::BST_OPER: begin
            if (BUS_ACK) begin
               s_next.bst       = cpq_pkg::BST_IDLE;
               s_next.bus.req   = 1'b0;
               s_next.opr_pend  = 1'b0;
               s_next.opr_done  = 1'b1;
               s_next.opr_rdata = BUS_RDATA;
               // Port input lands in the accumulator
               if (s_reg.opr.io && !s_reg.opr.wr) begin
                  if (s_reg.opr.word) s_next.gpr[`CPQ_R_ACC] = BUS_RDATA; // RL14
                  else s_next.gpr[`CPQ_R_ACC][7:0] = BUS_RDATA[7:0];
               end
            end
         end
         // Unused state code falls back to idle
         default: s_next.bst = cpq_pkg::BST_IDLE;
      endcase
      // Control transfer restarts the stream
      if (JMP_REQ) begin
         s_next.ip = JMP_OFS; // RL10
      end
      // Register port
      unique case (REG_OP)
         cpq_pkg::REG_NOP: ;
         cpq_pkg::REG_RD:  s_next.reg_rdata = reg_read(s_reg, REG_SEL);
         cpq_pkg::REG_WR_WORD: begin
            if (REG_SEL[3]) s_next.seg[REG_SEL[1:0]] = REG_WDATA; // RL18
            else s_next.gpr[REG_SEL[2:0]] = REG_WDATA; // RL1 RL12
         end
         cpq_pkg::REG_WR_LOW: begin
            if (is_data_reg(REG_SEL)) s_next.gpr[REG_SEL[2:0]][7:0] = REG_WDATA[7:0]; // RL13
         end
         cpq_pkg::REG_WR_HIGH: begin
            if (is_data_reg(REG_SEL)) s_next.gpr[REG_SEL[2:0]][15:8] = REG_WDATA[7:0]; // RL13
         end
         cpq_pkg::REG_MUL_BYTE: begin
            s_next.gpr[`CPQ_R_ACC] = MUL_RES[15:0]; // RL14
         end
         cpq_pkg::REG_MUL_WORD: begin
            s_next.gpr[`CPQ_R_ACC]  = MUL_RES[15:0]; // RL14
            s_next.gpr[`CPQ_R_DEXT] = MUL_RES[31:16];
         end
         default: ;
      endcase
      // Offset of the next byte to execute
      s_next.saved_ip = s_reg.ip - {13'h0, q_count}; // RL19
   end

   // State register
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         s_reg    <= '0;
         s_reg.ip <= `CPQ_IP_RST;
      end else if (CE) begin
         s_reg <= s_next;
      end
   end

   // Outputs
   assign BUS          = s_reg.bus;
   assign INS_VALID    = q_count != 3'h0; // RL20
   assign INS_BYTE     = q_head;
   assign OPR_DONE     = s_reg.opr_done;
   assign OPR_RDATA    = s_reg.opr_rdata;
   assign REG_RDATA    = s_reg.reg_rdata;
   assign ACC_WORD     = s_reg.gpr[`CPQ_R_ACC];
   assign SHIFT_COUNT  = s_reg.gpr[`CPQ_R_COUNT][7:0]; // RL15
   assign STRING_COUNT = s_reg.gpr[`CPQ_R_COUNT];
   assign SRC_INDEX    = s_reg.gpr[`CPQ_R_SRC]; // RL15
   assign TGT_INDEX    = s_reg.gpr[`CPQ_R_TGT];
   assign SAVED_IP     = s_reg.saved_ip;

   // Checks
   logic fetch_start;                         // Prefetch issued this cycle
   assign fetch_start = CE && s_reg.bst == cpq_pkg::BST_IDLE
                        && s_next.bst == cpq_pkg::BST_FETCH;

   sequence s_jump;
      CE && JMP_REQ;
   endsequence
   sequence s_flushed;
      q_count == 3'h0 && s_reg.ip == $past(JMP_OFS);
   endsequence

   AST_DEPTH: assert property (@(posedge REF_CLK) disable iff (RST) // RL5
      q_count <= 3'(DEPTH)) else $error("queue over depth");
   AST_SPACE: assert property (@(posedge REF_CLK) disable iff (RST) // RL7
      fetch_start |-> q_free >= NEED) else $error("fetch without room");
   AST_NO_PEND: assert property (@(posedge REF_CLK) disable iff (RST) // RL11
      fetch_start |-> !s_reg.opr_pend) else $error("fetch beside operand");
   AST_EVEN: assert property (@(posedge REF_CLK) disable iff (RST) // RL8
      (fetch_start && fetch_word) |=> BUS.word && !BUS.addr[0])
      else $error("word fetch at odd");
   AST_FLUSH: assert property (@(posedge REF_CLK) disable iff (RST) // RL10
      s_jump |=> s_flushed) else $error("jump did not flush");
   AST_HOLD: assert property (@(posedge REF_CLK) disable iff (RST) // RL3
      (CE && BUS.req && !BUS_ACK) |=> BUS.req && $stable(BUS.addr))
      else $error("bus request dropped");
   AST_IP: assert property (@(posedge REF_CLK) disable iff (RST) // RL19
      (CE && fetch_ack && !s_reg.discard && !JMP_REQ) |=>
      s_reg.ip == $past(s_reg.ip) + (WIDE_BUS && !$past(s_reg.ip[0]) ? 16'h2 : 16'h1))
      else $error("pointer step wrong");
   AST_BYTE: assert property (@(posedge REF_CLK) disable iff (RST) // RL13
      (CE && REG_OP == cpq_pkg::REG_WR_HIGH && !is_data_reg(REG_SEL)) |=> $stable(s_reg.gpr))
      else $error("byte write to word register");
   AST_OPR: assert property (@(posedge REF_CLK) disable iff (RST) // RL11
      (CE && s_reg.bst == cpq_pkg::BST_FETCH && s_reg.opr_pend && BUS_ACK)
      |=> (s_reg.bst == cpq_pkg::BST_IDLE) ##1 (s_reg.bst == cpq_pkg::BST_OPER || !$past(CE)))
      else $error("operand not next");
endmodule // cpq_core
`default_nettype wire

// File: cpq_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module cpq_mem_model (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Bus from the core
   input  wire cpq_pkg::cpq_bus_t bus,
   output logic                   ack,
   output cpq_pkg::cpq_word_t     rdata
);
   logic [1:0] dly_reg;                         // Wait states still to insert

   // Memory contents as a fixed function of the address
   function automatic logic [7:0] byte_at(input logic [19:0] a);
      return a[7:0] ^ {a[11:8], a[19:16]} ^ 8'hA5;
   endfunction

   // Answers each request after 0 to 2 wait states, one-cycle acknowledge
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ack     <= 1'b0;
         dly_reg <= 2'h0;
         rdata   <= 16'hFFFF;
      end else if (ack) begin
         // Hold time over: data no longer valid
         ack   <= 1'b0;
         rdata <= ~rdata;
      end else if (bus.req) begin
         if (dly_reg == 2'h0) begin
            // Aligned word, lower address in the low byte
            ack     <= 1'b1;
            rdata   <= {byte_at(bus.addr | 20'h1), byte_at(bus.addr & ~20'h1)};
            dly_reg <= 2'($urandom % 3);
         end else begin
            dly_reg <= dly_reg - 2'h1;
         end
      end else begin
         // Idle bus shows a changing pattern
         rdata <= ~rdata;
      end
   end
endmodule // cpq_mem_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   // Design stimulus and responses
   logic                 REF_CLK, RST, CE, BUS_ACK, INS_VALID, INS_TAKE, JMP_REQ, OPR_DONE;
   cpq_pkg::cpq_bus_t    BUS;
   cpq_pkg::cpq_word_t   BUS_RDATA, JMP_OFS, OPR_RDATA, REG_WDATA, REG_RDATA, ACC_WORD;
   cpq_pkg::cpq_word_t   STRING_COUNT, SRC_INDEX, TGT_INDEX, SAVED_IP;
   logic [7:0]           INS_BYTE, SHIFT_COUNT;
   cpq_pkg::cpq_opr_t    OPR;
   cpq_pkg::cpq_regop_t  REG_OP;
   logic [3:0]           REG_SEL;
   logic [31:0]          MUL_RES;
   // Reference model state
   int                   errors = 0, samples_checked = 0;
   logic [15:0]          exp_reg [12];
   logic [15:0]          ip_exp, w;
   logic [19:0]          a;

   cpq_core #(.WIDE_BUS(1'b1)) dut_u (.REF_CLK(REF_CLK), .RST(RST), .CE(CE), .BUS(BUS),
      .BUS_ACK(BUS_ACK), .BUS_RDATA(BUS_RDATA), .INS_VALID(INS_VALID), .INS_BYTE(INS_BYTE),
      .INS_TAKE(INS_TAKE), .JMP_REQ(JMP_REQ), .JMP_OFS(JMP_OFS), .OPR(OPR), .OPR_DONE(OPR_DONE),
      .OPR_RDATA(OPR_RDATA), .REG_OP(REG_OP), .REG_SEL(REG_SEL), .REG_WDATA(REG_WDATA),
      .MUL_RES(MUL_RES), .REG_RDATA(REG_RDATA), .ACC_WORD(ACC_WORD), .SHIFT_COUNT(SHIFT_COUNT),
      .STRING_COUNT(STRING_COUNT), .SRC_INDEX(SRC_INDEX), .TGT_INDEX(TGT_INDEX),
      .SAVED_IP(SAVED_IP));
   cpq_mem_model mem_u (.clk(REF_CLK), .rst(RST), .bus(BUS), .ack(BUS_ACK), .rdata(BUS_RDATA));

   // 100 ns clock
   initial begin
      REF_CLK = 1'b0;
      forever #50 REF_CLK = ~REF_CLK;
   end

   // Counts a comparison, reports a mismatch
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One register port operation, entered and left at a clock edge
   task automatic reg_op(input cpq_pkg::cpq_regop_t op, input logic [3:0] s);
      #1 REG_OP = op;
      REG_SEL = s;
      REG_WDATA = 16'($urandom);
      MUL_RES = $urandom;
      w = REG_WDATA;
      // Model of the register file
      case (op)
         cpq_pkg::REG_WR_WORD: exp_reg[s] = w;
         cpq_pkg::REG_WR_LOW: if (s < 4) exp_reg[s][7:0] = w[7:0];
         cpq_pkg::REG_WR_HIGH: if (s < 4) exp_reg[s][15:8] = w[7:0];
         cpq_pkg::REG_MUL_BYTE: exp_reg[0] = MUL_RES[15:0];
         cpq_pkg::REG_MUL_WORD: begin
            exp_reg[0] = MUL_RES[15:0];
            exp_reg[3] = MUL_RES[31:16];
         end
         default: ;
      endcase
      @(posedge REF_CLK);
   endtask

   // Read one register back and compare
   task automatic reg_rd(input logic [3:0] s);
      reg_op(cpq_pkg::REG_RD, s);
      #1 REG_OP = cpq_pkg::REG_NOP;
      chk(REG_RDATA, exp_reg[s]);
      @(posedge REF_CLK);
   endtask

   // Control transfer to a new offset
   task automatic jump(input logic [15:0] ofs);
      #1 JMP_REQ = 1'b1;
      JMP_OFS = ofs;
      ip_exp = ofs;
      @(posedge REF_CLK);
      #1 JMP_REQ = 1'b0;
      @(posedge REF_CLK);
   endtask

   // Consume n instruction bytes with random gaps
   task automatic take_n(input int n, input bit ip_chk);
      for (int k = 0; k < n; ) begin
         #1;
         if (ip_chk) chk(SAVED_IP, ip_exp);
         ip_chk = 1'b0;
         if (INS_VALID === 1'b1 && $urandom % 4 != 0) begin
            a = {exp_reg[8], 4'h0} + {4'h0, ip_exp};
            chk({8'h00, INS_BYTE}, {8'h00, mem_u.byte_at(a)});
            ip_exp++;
            k++;
            INS_TAKE = 1'b1;
         end else begin
            INS_TAKE = 1'b0;
         end
         @(posedge REF_CLK);
      end
      #1 INS_TAKE = 1'b0;
      @(posedge REF_CLK);
   endtask

   // Word operand read from the data segment
   task automatic opr_rd(input logic [15:0] ofs);
      #1 OPR = '{req: 1'b1, wr: 1'b0, word: 1'b1, io: 1'b0, seg: cpq_pkg::SEG_DATA,
                 ofs: ofs, wdata: 16'h0000};
      @(posedge REF_CLK);
      #1 OPR.req = 1'b0;
      for (int k = 0; k < 60 && OPR_DONE !== 1'b1; k++) begin
         @(posedge REF_CLK);
         #1;
      end
      a = {exp_reg[9], 4'h0} + {4'h0, ofs};
      chk({15'h0000, OPR_DONE}, 16'h0001);
      chk(OPR_RDATA, {mem_u.byte_at(a + 20'h1), mem_u.byte_at(a)});
      @(posedge REF_CLK);
   endtask

   // Verdict and end of run
   task automatic tally_and_finish();
      if (errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      #(100 * 20000);
      errors++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      RST = 1'b1;
      CE = 1'b1;
      INS_TAKE = 1'b0;
      JMP_REQ = 1'b0;
      JMP_OFS = 16'h0000;
      OPR = '0;
      REG_OP = cpq_pkg::REG_NOP;
      REG_SEL = 4'h0;
      REG_WDATA = 16'h0000;
      MUL_RES = 32'h0000_0000;
      ip_exp = 16'h0000;
      void'($urandom(32'h782b2245));
      foreach (exp_reg[i]) exp_reg[i] = 16'h0000;
      repeat (16) @(posedge REF_CLK);
      chk({14'h0000, BUS.req, INS_VALID}, 16'h0000);
      #1 RST = 1'b0;
      @(posedge REF_CLK);
      // Reset values, then word and byte writes on every register, multiply writes on registers 0 and 3
      for (int s = 0; s < 12; s++) reg_rd(4'(s));
      for (int s = 0; s < 12; s++) begin
         reg_op(cpq_pkg::REG_WR_WORD, 4'(s));
         reg_rd(4'(s));
         reg_op(cpq_pkg::REG_WR_LOW, 4'(s));
         reg_rd(4'(s));
         reg_op(cpq_pkg::REG_WR_HIGH, 4'(s));
         reg_rd(4'(s));
      end
      reg_op(cpq_pkg::REG_MUL_BYTE, 4'h0);
      reg_rd(4'h0);
      reg_op(cpq_pkg::REG_MUL_WORD, 4'h0);
      reg_rd(4'h3);
      // Implicit register views
      chk(ACC_WORD, exp_reg[0]);
      chk({8'h00, SHIFT_COUNT}, {8'h00, exp_reg[2][7:0]});
      chk(STRING_COUNT, exp_reg[2]);
      chk(SRC_INDEX, exp_reg[6]);
      chk(TGT_INDEX, exp_reg[7]);
      // Streams after odd and even jumps, operand read between bursts
      for (int j = 0; j < 4; j++) begin
         jump({16'($urandom) & 16'hFFFE} | 16'(j % 2));
         take_n(9, 1'b1);
         opr_rd(16'($urandom) & 16'hFFFE);
         take_n(9, 1'b0);
      end
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
